// file: src/cfg_space_pkg.sv
// Constants shared by the configuration space decode and gating logic.
package cfg_space_pkg;

  // ==========================================================================
  // Configuration register indexes.
  localparam logic [7:0] IDX_CFG_BASE_LO  = 8'h12;
  localparam logic [7:0] IDX_CFG_BASE_HI  = 8'h13;
  localparam logic [7:0] IDX_PP_BASE      = 8'h23;
  localparam logic [7:0] IDX_SER_BASE     = 8'h24;
  localparam logic [7:0] IDX_RT_BASE_LO   = 8'h2f;
  localparam logic [7:0] IDX_RT_BASE_HI   = 8'h30;
  localparam logic [7:0] IDX_GPIO_POL     = 8'h38;
  localparam logic [7:0] IDX_PME_CTL      = 8'h39;

  // ==========================================================================
  // Values after reset.
  localparam logic [7:0] RST_GPIO_POL     = 8'h00;
  localparam logic [7:0] RST_PME_CTL      = 8'h80;
  localparam logic [7:0] RST_BASE         = 8'h00;

  // ==========================================================================
  // Field positions and read masks.
  localparam int         PME_POL_BIT      = 6;
  localparam int         PME_OD_BIT       = 7;
  localparam logic [7:0] MASK_PME_CTL     = 8'hc0;
  localparam logic [7:0] MASK_GPIO_POL    = 8'hf0;
  localparam logic [7:0] MASK_RT_BASE_LO  = 8'hc0;
  localparam int         GPIO_LSB         = 4;

  // ==========================================================================
  // Config port power-up location, chosen by the strap.
  localparam logic [15:0] CFG_BASE_STRAP0 = 16'h002e;
  localparam logic [15:0] CFG_BASE_STRAP1 = 16'h004e;

  // Entry and exit keys written to the index port.
  localparam logic [7:0] CFG_ENTER_KEY    = 8'h55;
  localparam logic [7:0] CFG_EXIT_KEY     = 8'haa;

  // ==========================================================================
  // Runtime block offsets.
  localparam logic [1:0] RT_OFF_STS       = 2'h0;
  localparam logic [1:0] RT_OFF_EN        = 2'h1;
  localparam logic [1:0] RT_OFF_GPIO      = 2'h2;

  // Window numbering for the address decoders.
  localparam int         WIN_PP           = 0;
  localparam int         WIN_PP_EXT       = 1;
  localparam int         WIN_SER          = 2;
  localparam int         WIN_RT           = 3;
  localparam int         WIN_CFG          = 4;
  localparam int         NUM_WIN          = 5;
  localparam logic [15:0] PP_EXT_OFFSET   = 16'h0400;

  // Extended-control modes in which the interrupt bypasses its enable bit.
  localparam logic [2:0] ECR_FIFO         = 3'h2;
  localparam logic [2:0] ECR_ECP          = 3'h3;
  localparam logic [2:0] ECR_TEST         = 3'h6;

endpackage : cfg_space_pkg

// file: src/io_window.sv
// Address window compare: one base, one power-of-two span, one enable.
`timescale 1ns/1ps
`default_nettype none
module io_window
  import cfg_space_pkg::*;
(
  // Window setup.
  input  wire logic [15:0] base,
  input  wire logic [15:0] span_mask,
  input  wire logic        win_en,
  // Address under test.
  input  wire logic [15:0] addr,
  output logic             hit
);

  // ==========================================================================
  // Low address bits inside the span are don't-care; all others must match.
  assign hit = win_en && ((addr & ~span_mask) == (base & ~span_mask));

endmodule : io_window
`default_nettype wire

// file: src/pp_req_gate.sv
// Parallel port interrupt and DMA request gating by mode and enable bits.
`timescale 1ns/1ps
`default_nettype none
module pp_req_gate
  import cfg_space_pkg::*;
(
  // Block level enables.
  input  wire logic       dev_en,
  // Enable bits held inside the parallel port.
  input  wire logic       pp_irq_enable_bit,
  input  wire logic       pp_dma_enable_bit,
  input  wire logic [2:0] ecr_mode,
  // Raw requests and gated results.
  input  wire logic       irq_raw,
  input  wire logic       drq_raw,
  output logic            irq,
  output logic            drq
);

  // Modes whose interrupt stays on whatever the enable bit says.
  function automatic logic irq_forced(input logic [2:0] m);
    irq_forced = (m == ECR_FIFO) || (m == ECR_ECP) || (m == ECR_TEST);
  endfunction : irq_forced

  // ==========================================================================
  // Inner enables apply on top of the activate and base checks.
  always_comb begin
    irq = dev_en && irq_raw && (irq_forced(ecr_mode) || pp_irq_enable_bit);
    drq = dev_en && drq_raw && pp_dma_enable_bit;
  end

endmodule : pp_req_gate
`default_nettype wire

// file: src/cfg_space.sv
// Configuration port, base decode, runtime block, pin polarity and request gating.
//
// What this block does
// - Polarity register reachable only at index 38h
// - Bits 7:4 invert host pins, reset zero
// - Power-event control reachable only at index 39h
// - Bit 6 inverts power-event pin, reset zero
// - Bit 7 selects open drain, reset 80h
// - Parallel base at 23h, 4 or 8 aligned
// - Serial base at 24h, eight offsets decoded
// - Runtime base at 2Fh/30h, status enable data
// - Config port base at 12h/13h, index/data
// - Strap picks 2Eh or 4Eh at power-up
// - Inner enable bits suppress IRQ and DMA
// - SPP/EPP interrupt gated by control bit four
// - Parallel DMA gated only by DMA enable
// - Modes 010, 011, 110 force interrupt on
// - Runtime block off when base 11:8 zero
`timescale 1ns/1ps
`default_nettype none
module cfg_space
  import cfg_space_pkg::*;
#(
  parameter int GPIO_N = 4
)(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Strap sampled after reset release.
  input  wire logic              config_port_strap,
  // Host I/O cycles, one per valid pulse.
  input  wire logic              io_valid,
  input  wire logic              io_write,
  input  wire logic [15:0]       io_addr,
  input  wire logic [7:0]        io_wdata,
  output logic [7:0]             io_rdata_r,
  output logic                   io_ack_r,
  // Address claims for the other logical blocks.
  output logic                   pp_sel_r,
  output logic                   ser_sel_r,
  // Host GPIO pins.
  input  wire logic [GPIO_N-1:0] host_gpio_in,
  input  wire logic [GPIO_N-1:0] host_gpio_dir,
  output logic [GPIO_N-1:0]      host_gpio_out_r,
  output logic [GPIO_N-1:0]      host_gpio_oe_b_r,
  // Power-event pin and its event source.
  input  wire logic              pme_event,
  output logic                   power_event_pin_out_r,
  output logic                   power_event_pin_oe_b_r,
  // Block activates and parallel port request gating.
  input  wire logic              pp_activate,
  input  wire logic              ser_activate,
  input  wire logic              pp_irq_enable_bit,
  input  wire logic              pp_dma_enable_bit,
  input  wire logic [2:0]        ecr_mode,
  input  wire logic              pp_irq_raw,
  input  wire logic              pp_drq_raw,
  output logic                   pp_irq_r,
  output logic                   pp_drq_r
);

  // ==========================================================================
  // Whole state of the block.
  typedef struct packed {
    logic              cfg_active;        // Configuration state entered.
    logic              strap_done;        // Power-up location loaded.
    logic [7:0]        index;             // Config index register.
    logic [7:0]        cfg_base_lo;       // Config port base low.
    logic [7:0]        cfg_base_hi;       // Config port base high.
    logic [7:0]        pp_base;           // Parallel base, address bits 9:2.
    logic [7:0]        ser_base;          // Serial base, address bits 9:3 in 7:1.
    logic [7:0]        rt_base_lo;        // Runtime base bits 3:2 in 7:6.
    logic [7:0]        rt_base_hi;        // Runtime base bits 11:4.
    logic [7:0]        gpio_pol;          // Host pin polarity.
    logic [7:0]        pme_ctl;           // Power-event type and polarity.
    logic              event_status;      // Sticky power event.
    logic              event_enable;      // Routes the event to the pin.
    logic [GPIO_N-1:0] gpio_data;         // Host pin data as software sees it.
    logic [7:0]        rdata;             // Read answer.
    logic              ack;               // Answer strobe.
    logic              pp_sel;            // Parallel port claim.
    logic              ser_sel;           // Serial port claim.
    logic [GPIO_N-1:0] gpio_out;          // Pin drive values.
    logic [GPIO_N-1:0] gpio_oe_b;         // Pin enables, low drives.
    logic              pme_out;           // Power-event pin level.
    logic              pme_oe_b;          // Power-event enable, low drives.
    logic              pp_irq;            // Gated interrupt.
    logic              pp_drq;            // Gated DMA request.
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================================
  // Window bases derived from the base registers.
  logic [15:0]        win_base   [NUM_WIN];  // Base of each window.
  logic [15:0]        win_mask   [NUM_WIN];  // Don't-care low bits.
  logic [NUM_WIN-1:0] win_en;                // Window enabled.
  logic [NUM_WIN-1:0] win_hit;               // Address falls in window.
  logic [15:0]        pp_base_addr;          // Parallel port base.
  logic               pp_irq_g;              // Gated interrupt, unregistered.
  logic               pp_drq_g;              // Gated DMA, unregistered.
  logic               pp_valid;              // Parallel base in range.

  always_comb begin
    pp_base_addr = {6'h00, st_r.pp_base, 2'h0};
    pp_valid     = st_r.pp_base[7:6] != 2'h0;
    // A base on an 8-byte boundary opens the EPP offsets +4..+7.
    win_base[WIN_PP]    = pp_base_addr;
    win_mask[WIN_PP]    = st_r.pp_base[0] ? 16'h0003 : 16'h0007;
    win_en[WIN_PP]      = pp_valid && pp_activate;
    win_base[WIN_PP_EXT] = pp_base_addr + PP_EXT_OFFSET;
    win_mask[WIN_PP_EXT] = 16'h0003;
    win_en[WIN_PP_EXT]   = pp_valid && pp_activate;
    win_base[WIN_SER]   = {6'h00, st_r.ser_base[7:1], 3'h0};
    win_mask[WIN_SER]   = 16'h0007;
    win_en[WIN_SER]     = (st_r.ser_base[7:6] != 2'h0) && ser_activate;
    win_base[WIN_RT]    = {4'h0, st_r.rt_base_hi, st_r.rt_base_lo[7:6], 2'h0};
    win_mask[WIN_RT]    = 16'h0003;
    win_en[WIN_RT]      = st_r.rt_base_hi[7:4] != 4'h0;
    win_base[WIN_CFG]   = {5'h00, st_r.cfg_base_hi[2:0], st_r.cfg_base_lo[7:1], 1'b0};
    win_mask[WIN_CFG]   = 16'h0001;
    win_en[WIN_CFG]     = st_r.strap_done;
  end

  // One comparator per window.
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WIN; gw++) begin : g_win
      io_window u_win (
        .base      (win_base[gw]),
        .span_mask (win_mask[gw]),
        .win_en    (win_en[gw]),
        .addr      (io_addr),
        .hit       (win_hit[gw])
      );
    end
  endgenerate

  // Interrupt and DMA gating for the parallel port.
  pp_req_gate u_pp_gate (
    .dev_en            (pp_valid && pp_activate),
    .pp_irq_enable_bit (pp_irq_enable_bit),
    .pp_dma_enable_bit (pp_dma_enable_bit),
    .ecr_mode          (ecr_mode),
    .irq_raw           (pp_irq_raw),
    .drq_raw           (pp_drq_raw),
    .irq               (pp_irq_g),
    .drq               (pp_drq_g)
  );

  // ==========================================================================
  // Config data read mux; reserved bits and unused indexes read zero.
  function automatic logic [7:0] cfg_read(input state_t s);
    case (s.index)
      IDX_CFG_BASE_LO: cfg_read = s.cfg_base_lo;
      IDX_CFG_BASE_HI: cfg_read = s.cfg_base_hi;
      IDX_PP_BASE:     cfg_read = s.pp_base;
      IDX_SER_BASE:    cfg_read = s.ser_base;
      IDX_RT_BASE_LO:  cfg_read = s.rt_base_lo & MASK_RT_BASE_LO;
      IDX_RT_BASE_HI:  cfg_read = s.rt_base_hi;
      IDX_GPIO_POL:    cfg_read = s.gpio_pol & MASK_GPIO_POL;
      IDX_PME_CTL:     cfg_read = s.pme_ctl & MASK_PME_CTL;
      default:         cfg_read = 8'h00;
    endcase
  endfunction : cfg_read

  // ==========================================================================
  // Next state: bus cycles, event capture, pin drive.
  logic              cfg_idx_hit;    // Cycle on the index port.
  logic              cfg_dat_hit;    // Cycle on the data port.
  logic              rt_hit;         // Cycle on the runtime block.
  logic [1:0]        rt_off;         // Offset in the runtime block.
  logic [GPIO_N-1:0] pol;            // Per-pin inversion.
  logic [GPIO_N-1:0] pin_view;       // Pin data seen by software.
  logic              pme_assert;     // Power event is pending.
  logic              pme_level;      // Level wanted on the pin.

  always_comb begin
    st_nxt      = st_r;
    cfg_idx_hit = io_valid && win_hit[WIN_CFG] && !io_addr[0];
    cfg_dat_hit = io_valid && win_hit[WIN_CFG] && io_addr[0];
    rt_hit      = io_valid && win_hit[WIN_RT];
    rt_off      = io_addr[1:0];
    pol         = st_r.gpio_pol[GPIO_LSB +: GPIO_N];
    // Inputs are inverted on the way in, outputs read back as written.
    pin_view    = (host_gpio_dir & st_r.gpio_data)
                | (~host_gpio_dir & (host_gpio_in ^ pol));
    st_nxt.ack  = 1'b0;

    // The strap is caught on the first edge after reset lets go.
    if (!st_r.strap_done) begin
      st_nxt.strap_done  = 1'b1;
      st_nxt.cfg_base_lo = config_port_strap ? CFG_BASE_STRAP1[7:0]
                                             : CFG_BASE_STRAP0[7:0];
      st_nxt.cfg_base_hi = config_port_strap ? CFG_BASE_STRAP1[15:8]
                                             : CFG_BASE_STRAP0[15:8];
    end

    // Index port: enter key only outside config state; exit key and index loads only in it.
    if (cfg_idx_hit) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = st_r.cfg_active ? st_r.index : 8'h00;
      if (io_write) begin
        if (!st_r.cfg_active && io_wdata == CFG_ENTER_KEY) begin
          st_nxt.cfg_active = 1'b1;
        end else if (st_r.cfg_active && io_wdata == CFG_EXIT_KEY) begin
          st_nxt.cfg_active = 1'b0;
        end else if (st_r.cfg_active) begin
          st_nxt.index = io_wdata;
        end
      end
    end

    // Data port: only in config state; otherwise writes drop, reads give zero.
    if (cfg_dat_hit) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = st_r.cfg_active ? cfg_read(st_r) : 8'h00;
      if (io_write && st_r.cfg_active) begin
        case (st_r.index)
          IDX_CFG_BASE_LO: st_nxt.cfg_base_lo = io_wdata;
          IDX_CFG_BASE_HI: st_nxt.cfg_base_hi = io_wdata;
          IDX_PP_BASE:     st_nxt.pp_base     = io_wdata;
          IDX_SER_BASE:    st_nxt.ser_base    = io_wdata;
          IDX_RT_BASE_LO:  st_nxt.rt_base_lo  = io_wdata & MASK_RT_BASE_LO;
          IDX_RT_BASE_HI:  st_nxt.rt_base_hi  = io_wdata;
          IDX_GPIO_POL:    st_nxt.gpio_pol    = io_wdata & MASK_GPIO_POL;
          IDX_PME_CTL:     st_nxt.pme_ctl     = io_wdata & MASK_PME_CTL;
          default: begin
          end
        endcase
      end
    end

    // Runtime block: status, enable, pin data; offset three reads zero.
    if (rt_hit) begin
      st_nxt.ack = 1'b1;
      case (rt_off)
        RT_OFF_STS: begin
          st_nxt.rdata = {7'h00, st_r.event_status};
          if (io_write && io_wdata[0]) begin
            st_nxt.event_status = 1'b0;
          end
        end
        RT_OFF_EN: begin
          st_nxt.rdata = {7'h00, st_r.event_enable};
          if (io_write) begin
            st_nxt.event_enable = io_wdata[0];
          end
        end
        RT_OFF_GPIO: begin
          st_nxt.rdata = 8'h00;
          st_nxt.rdata[GPIO_LSB +: GPIO_N] = pin_view;
          if (io_write) begin
            st_nxt.gpio_data = io_wdata[GPIO_LSB +: GPIO_N];
          end
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    // A new event outranks a clear in the same cycle.
    if (pme_event) begin
      st_nxt.event_status = 1'b1;
    end

    // Pin drive follows the registered state one cycle later.
    st_nxt.gpio_out   = st_r.gpio_data ^ pol;
    st_nxt.gpio_oe_b  = ~host_gpio_dir;
    pme_assert        = st_r.event_status && st_r.event_enable;
    // Non-inverted means an active-low pin; inverted means active high.
    pme_level         = ~(pme_assert ^ st_r.pme_ctl[PME_POL_BIT]);
    if (st_r.pme_ctl[PME_OD_BIT]) begin
      // Open drain can only pull low, so a high level releases the pin.
      st_nxt.pme_out  = 1'b0;
      st_nxt.pme_oe_b = pme_level;
    end else begin
      st_nxt.pme_out  = pme_level;
      st_nxt.pme_oe_b = 1'b0;
    end

    // Claims and gated requests.
    st_nxt.pp_sel  = io_valid && (win_hit[WIN_PP] || win_hit[WIN_PP_EXT]);
    st_nxt.ser_sel = io_valid && win_hit[WIN_SER];
    st_nxt.pp_irq  = pp_irq_g;
    st_nxt.pp_drq  = pp_drq_g;
  end

  // ==========================================================================
  // Single state register; reset loads constants only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r             <= '0;
      st_r.cfg_base_lo <= RST_BASE;
      st_r.cfg_base_hi <= RST_BASE;
      st_r.gpio_pol    <= RST_GPIO_POL;
      st_r.pme_ctl     <= RST_PME_CTL;
      st_r.gpio_oe_b   <= '1;
      st_r.pme_oe_b    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register.
  assign io_rdata_r             = st_r.rdata;
  assign io_ack_r               = st_r.ack;
  assign pp_sel_r               = st_r.pp_sel;
  assign ser_sel_r              = st_r.ser_sel;
  assign host_gpio_out_r        = st_r.gpio_out;
  assign host_gpio_oe_b_r       = st_r.gpio_oe_b;
  assign power_event_pin_out_r  = st_r.pme_out;
  assign power_event_pin_oe_b_r = st_r.pme_oe_b;
  assign pp_irq_r               = st_r.pp_irq;
  assign pp_drq_r               = st_r.pp_drq;

endmodule : cfg_space
`default_nettype wire

// file: sim/cfg_space_monitor.sv
// Port-level checker for the configuration space block.
`timescale 1ns/1ps
`default_nettype none
module cfg_space_monitor #(
  parameter int GPIO_N = 4
)(
  // Clock, reset and host cycles.
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              io_valid,
  input wire logic [7:0]        io_rdata_r,
  input wire logic              io_ack_r,
  input wire logic              pp_sel_r,
  input wire logic              ser_sel_r,
  // Pins.
  input wire logic [GPIO_N-1:0] host_gpio_dir,
  input wire logic [GPIO_N-1:0] host_gpio_oe_b_r,
  input wire logic              power_event_pin_out_r,
  input wire logic              power_event_pin_oe_b_r,
  // Request gating.
  input wire logic              pp_activate,
  input wire logic              pp_irq_enable_bit,
  input wire logic              pp_dma_enable_bit,
  input wire logic [2:0]        ecr_mode,
  input wire logic              pp_irq_raw,
  input wire logic              pp_drq_raw,
  input wire logic              pp_irq_r,
  input wire logic              pp_drq_r
);
  // ==========================================================================
  // Checks; all in the one clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ack_cause: assert property (io_ack_r |-> $past(io_valid))
    else $error("answer without a host cycle");
  chk_rdata_hold: assert property (!io_ack_r |-> $stable(io_rdata_r))
    else $error("read data moved without an answer");
  chk_ser_cause: assert property (ser_sel_r |-> $past(io_valid))
    else $error("serial claim without a host cycle");
  chk_pp_cause: assert property (pp_sel_r |-> $past(io_valid))
    else $error("parallel claim without a host cycle");
  chk_irq_gate: assert property (pp_irq_r |-> $past(pp_activate && pp_irq_raw &&
    (pp_irq_enable_bit || ecr_mode inside {3'h2, 3'h3, 3'h6}))) else $error("interrupt not gated");
  chk_drq_gate: assert property (pp_drq_r |->
    $past(pp_activate && pp_drq_raw && pp_dma_enable_bit)) else $error("dma request not gated");
  chk_mode_forces: assert property ((pp_irq_r && pp_activate && pp_irq_raw &&
    ecr_mode inside {3'h2, 3'h3, 3'h6}) |=> pp_irq_r) else $error("forced interrupt dropped");
  chk_od_release: assert property (power_event_pin_oe_b_r |-> !power_event_pin_out_r)
    else $error("released event pin drives high");
  chk_oe_dir: assert property ($past(rst_b) |-> host_gpio_oe_b_r == ~$past(host_gpio_dir))
    else $error("pin enable does not follow direction");
  // Main scenarios reached.
  cov_ack: cover property (io_ack_r);
  cov_irq: cover property (pp_irq_r);
  cov_drq: cover property (pp_drq_r);
  cov_pme: cover property (!power_event_pin_oe_b_r);
endmodule : cfg_space_monitor

bind cfg_space cfg_space_monitor #(.GPIO_N(GPIO_N)) mon_u (.clk, .rst_b, .io_valid,
  .io_rdata_r, .io_ack_r, .pp_sel_r, .ser_sel_r, .host_gpio_dir, .host_gpio_oe_b_r,
  .power_event_pin_out_r, .power_event_pin_oe_b_r, .pp_activate, .pp_irq_enable_bit,
  .pp_dma_enable_bit, .ecr_mode, .pp_irq_raw, .pp_drq_raw, .pp_irq_r, .pp_drq_r);
`default_nettype wire

// file: sim/host_io_model.sv
// Host model issuing single-byte I/O cycles into the block.
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
  // Clock and request.
  input  wire logic        clk,
  output logic             io_valid,
  output logic             io_write,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata,
  // Answer and claims.
  input  wire logic [7:0]  io_rdata_r,
  input  wire logic        io_ack_r,
  input  wire logic        pp_sel_r,
  input  wire logic        ser_sel_r
);
  initial begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
  end
  // One cycle; flags are {ack, parallel claim, serial claim}.
  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic [2:0] fl);
    @(posedge clk);
    io_valid <= 1'b1;
    io_write <= w;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge clk);
    io_valid <= 1'b0;
    // An idle bus shows the inverse so stale values never match by luck.
    io_addr  <= ~a;
    io_wdata <= ~d;
    #1;
    rd = io_rdata_r;
    fl = {io_ack_r, pp_sel_r, ser_sel_r};
  endtask : cycle
endmodule : host_io_model
`default_nettype wire

// file: sim/cfg_space_tb.sv
// Self-checking bench for the configuration space block.
`timescale 1ns/1ps
`default_nettype none
module cfg_space_tb;
  import cfg_space_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, config_port_strap = 1'b0, pme_event = 1'b0;
  logic io_valid, io_write, io_ack_r, pp_sel_r, ser_sel_r, pp_irq_r, pp_drq_r;
  logic power_event_pin_out_r, power_event_pin_oe_b_r;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata_r, rd;
  logic [3:0]  host_gpio_in = 4'h5, host_gpio_dir = 4'h0, host_gpio_out_r, host_gpio_oe_b_r;
  logic pp_activate = 1'b1, ser_activate = 1'b1, pp_irq_enable_bit = 1'b0;
  logic pp_dma_enable_bit = 1'b0, pp_irq_raw = 1'b0, pp_drq_raw = 1'b0;
  logic [2:0]  ecr_mode = 3'h0, fl;
  logic [15:0] cfg = 16'h002e;
  int miscompares = 0, checked = 0;

  cfg_space #(.GPIO_N(4)) dut_u (.clk, .rst_b, .config_port_strap, .io_valid, .io_write,
    .io_addr, .io_wdata, .io_rdata_r, .io_ack_r, .pp_sel_r, .ser_sel_r, .host_gpio_in,
    .host_gpio_dir, .host_gpio_out_r, .host_gpio_oe_b_r, .pme_event, .power_event_pin_out_r,
    .power_event_pin_oe_b_r, .pp_activate, .ser_activate, .pp_irq_enable_bit,
    .pp_dma_enable_bit, .ecr_mode, .pp_irq_raw, .pp_drq_raw, .pp_irq_r, .pp_drq_r);
  host_io_model host_u (.clk, .io_valid, .io_write, .io_addr, .io_wdata, .io_rdata_r,
    .io_ack_r, .pp_sel_r, .ser_sel_r);

  // ==========================================================================
  // Clock and tasks.
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic stop_test();
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_u.cycle(1'b1, a, d, rd, fl);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    host_u.cycle(1'b0, a, 8'h00, rd, fl);
    chk(rd, exp);
  endtask : rdc
  // Index first, then data; the pair only lands in config state.
  task automatic cw(input logic [7:0] idx, input logic [7:0] d);
    wr(cfg, idx);
    wr(cfg + 16'h1, d);
  endtask : cw
  task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
    wr(cfg, idx);
    rdc(cfg + 16'h1, exp);
  endtask : cr
  task automatic pins(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    #1 chk({6'h0, power_event_pin_out_r, power_event_pin_oe_b_r}, exp);
  endtask : pins
  // Walks a parallel window: offsets below n are claimed, n is not.
  task automatic ppwin(input logic [7:0] r, input logic [15:0] b, input int n);
    cw(IDX_PP_BASE, r);
    for (int i = 0; i <= n; i++) begin
      wr(b + 16'(i), 8'h00);
      chk({7'h0, fl[1]}, {7'h0, 1'(i < n)});
    end
  endtask : ppwin

  // ==========================================================================
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wr(cfg, CFG_ENTER_KEY);
    chk({5'h0, fl}, 8'h04);
    cr(IDX_GPIO_POL, 8'h00);
    cr(IDX_PME_CTL, 8'h80);
    cw(IDX_PME_CTL, 8'hff);
    cr(IDX_PME_CTL, 8'hc0);
    cw(IDX_GPIO_POL, 8'hff);
    cr(IDX_GPIO_POL, 8'hf0);
    // Outside config state index and data writes must be dropped.
    wr(cfg, CFG_EXIT_KEY);
    wr(cfg, IDX_PME_CTL);
    wr(cfg + 16'h1, 8'h00);
    rdc(cfg + 16'h1, 8'h00);
    wr(cfg, CFG_ENTER_KEY);
    cr(IDX_PME_CTL, 8'hc0);
    cw(IDX_PME_CTL, 8'h80);
    // Runtime block with base bits 11:8 zero stays silent.
    cw(IDX_RT_BASE_HI, 8'h0f);
    rdc(16'h00f2, 8'h00);
    chk({5'h0, fl}, 8'h00);
    cw(IDX_RT_BASE_HI, 8'h12);
    rdc(16'h0122, 8'ha0);
    rdc(16'h0123, 8'h00);
    @(posedge clk);
    host_gpio_dir <= 4'hf;
    wr(16'h0122, 8'h30);
    repeat (2) @(posedge clk);
    #1 chk({host_gpio_oe_b_r, host_gpio_out_r}, 8'h0c);
    // Event raised, then polarity and buffer type changed, then cleared.
    wr(16'h0121, 8'h01);
    @(posedge clk);
    pme_event <= 1'b1;
    @(posedge clk);
    pme_event <= 1'b0;
    pins(8'h00);
    cw(IDX_PME_CTL, 8'h40);
    pins(8'h02);
    wr(16'h0120, 8'h01);
    pins(8'h00);
    cw(IDX_PME_CTL, 8'h80);
    pins(8'h01);
    // An event and a clear in one cycle: the event must win.
    fork
      wr(16'h0120, 8'h01);
      begin
        @(posedge clk) pme_event <= 1'b1;
        @(posedge clk) pme_event <= 1'b0;
      end
    join
    rdc(16'h0120, 8'h01);
    cw(IDX_SER_BASE, 8'h7f);
    for (int i = 0; i <= 8; i++) begin
      wr(16'h01f8 + 16'(i), 8'h00);
      chk({7'h0, fl[0]}, {7'h0, 1'(i < 8)});
    end
    ppwin(8'hc1, 16'h0304, 4);
    ppwin(8'hc2, 16'h0308, 8);
    // Every mode with the enables off, then on.
    @(posedge clk);
    pp_activate <= 1'b1;
    pp_irq_raw  <= 1'b1;
    pp_drq_raw  <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 8; m++) begin
        @(posedge clk);
        ecr_mode          <= 3'(m);
        pp_irq_enable_bit <= 1'(e);
        pp_dma_enable_bit <= 1'(e);
        repeat (2) @(posedge clk);
        #1 chk({6'h0, pp_irq_r, pp_drq_r}, {6'h0, 1'(e) | (3'(m) inside {3'h2, 3'h3, 3'h6}),
          1'(e)});
      end
    end
    @(posedge clk);
    pp_activate <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({6'h0, pp_irq_r, pp_drq_r}, 8'h00);
    // Relocate the config port in two steps.
    cw(IDX_CFG_BASE_LO, 8'h40);
    cfg = 16'h0040;
    cw(IDX_CFG_BASE_HI, 8'h01);
    cfg = 16'h0140;
    cr(IDX_GPIO_POL, 8'hf0);
    wr(16'h002e, IDX_GPIO_POL);
    chk({5'h0, fl}, 8'h00);
    // A second reset with the strap high moves the port to its other home.
    @(posedge clk);
    rst_b             <= 1'b0;
    config_port_strap <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cfg = CFG_BASE_STRAP1;
    repeat (2) @(posedge clk);
    wr(cfg, CFG_ENTER_KEY);
    chk({5'h0, fl}, 8'h04);
    cr(IDX_GPIO_POL, 8'h00);
    stop_test();
  end
endmodule : cfg_space_tb
`default_nettype wire
